// ### include/cracc_pkg.sv
package cracc_pkg;

    // control token values carried on the interconnect
    localparam logic [7:0] CRACC_TOK_WRITE   = 8'hC0;   // tile or node write opening
    localparam logic [7:0] CRACC_TOK_READ    = 8'hC1;   // tile or node read opening
    localparam logic [7:0] CRACC_TOK_PREAD   = 8'h25;   // peripheral read opening
    localparam logic [7:0] CRACC_TOK_PWRITE  = 8'h24;   // peripheral write opening
    localparam logic [7:0] CRACC_TOK_END     = 8'h01;   // closes every message
    localparam logic [7:0] CRACC_TOK_OK      = 8'h03;   // success reply head
    localparam logic [7:0] CRACC_TOK_FAIL    = 8'h04;   // failure reply head

    // low part of the destination the requester aims its channel end at
    localparam logic [15:0] CRACC_DEST_TILE  = 16'hC20C;
    localparam logic [15:0] CRACC_DEST_NODE  = 16'hC30C;
    localparam logic [7:0]  CRACC_DEST_PERI  = 8'h02;

    // reply id whose low byte is all ones asks for no reply to a write
    localparam logic [7:0] CRACC_QUIET_MASK  = 8'hFF;

    // message field lengths in bytes, minus one (counter end values)
    localparam logic [7:0] CRACC_HDR_LAST    = 8'h02;   // 24-bit reply id
    localparam logic [7:0] CRACC_REG_LAST    = 8'h01;   // 16-bit register number
    localparam logic [7:0] CRACC_WORD_LAST   = 8'h03;   // 32-bit data word
    localparam logic [7:0] CRACC_ONE         = 8'h01;

    // storage geometry
    localparam int          CRACC_PER_IDW    = 2;
    localparam int          CRACC_PER_AW     = 6;
    localparam logic [15:0] CRACC_CFG_WORDS  = 16'h0010;
    localparam logic [8:0]  CRACC_PER_BYTES  = 9'h040;
    localparam logic [7:0]  CRACC_PER_IDS    = 8'h04;
    localparam logic [31:0] CRACC_WORD_RST   = 32'h0000_0000;
    localparam logic [7:0]  CRACC_BYTE_RST   = 8'h00;

    // target register space of a message
    typedef enum logic [1:0] {
        CRACC_SP_TILE,
        CRACC_SP_NODE,
        CRACC_SP_PERI,
        CRACC_SP_NONE
    } cracc_space_t;

    // kind of request being served
    typedef enum logic [1:0] {
        CRACC_OP_WR,
        CRACC_OP_RD,
        CRACC_OP_PRD,
        CRACC_OP_PWR
    } cracc_op_t;

    // one token on the link: control flag plus byte
    typedef struct packed {
        logic       ctrl;
        logic [7:0] data;
    } cracc_tok_t;

endpackage

// ### logic/cracc_store.sv
`timescale 1ns/1ps
`default_nettype none

module cracc_store
    import cracc_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire cracc_space_t space,
    input  wire logic [7:0]   pid,
    input  wire logic [15:0]  addr,
    input  wire logic         we,
    input  wire logic [31:0]  wdata,
    output logic              hit,
    output logic [31:0]       rword,
    output logic [7:0]        rbyte
);

    localparam int PER_DEPTH = 1 << (CRACC_PER_IDW + CRACC_PER_AW);
    localparam int CFG_DEPTH = 16;

    logic [31:0] tile_mem [CFG_DEPTH];   // tile configuration words
    logic [31:0] node_mem [CFG_DEPTH];   // node configuration words
    logic [7:0]  per_mem  [PER_DEPTH];   // peripheral bytes, all peripherals

    wire logic [3:0] word_idx = addr[3:0];
    wire logic [CRACC_PER_IDW+CRACC_PER_AW-1:0] per_idx =
        {pid[CRACC_PER_IDW-1:0], addr[CRACC_PER_AW-1:0]};
    wire logic cfg_hit = addr < CRACC_CFG_WORDS;
    wire logic per_hit = (pid < CRACC_PER_IDS) && ({1'b0, addr[7:0]} < CRACC_PER_BYTES) && (addr[15:8] == 8'h00);

    // reads are combinational so a byte stream can be fed one per cycle
    assign hit   = (space == CRACC_SP_PERI) ? per_hit : ((space == CRACC_SP_NONE) ? 1'b0 : cfg_hit);
    assign rword = (space == CRACC_SP_NODE) ? node_mem[word_idx] : tile_mem[word_idx];
    assign rbyte = per_mem[per_idx];

    ////////////////////////////////////////////////////////////////////////
    // storage update; writes outside the space are dropped, never aliased
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CFG_DEPTH; i++) begin
                tile_mem[i] <= CRACC_WORD_RST;
                node_mem[i] <= CRACC_WORD_RST;
            end
            for (int j = 0; j < PER_DEPTH; j++) begin
                per_mem[j] <= CRACC_BYTE_RST;
            end
        end else if (we && hit) begin
            unique case (space)
                CRACC_SP_TILE: tile_mem[word_idx] <= wdata;
                CRACC_SP_NODE: node_mem[word_idx] <= wdata;
                CRACC_SP_PERI: per_mem[per_idx]   <= wdata[7:0];
                CRACC_SP_NONE: ;
            endcase
        end
    end

endmodule

`default_nettype wire

// ### logic/cracc_agent.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - write: 192, reply id, reg16, data32, 1
// - write reply: 3,1 on success; 4,1 failure
// - read: 193, reply id, reg16, then 1
// - read reply: 3, word, 1; else 4,1
// - peripheral read: 37, reply id, reg8, size8, 1
// - peripheral read reply: 3, data, 1; else 4,1
// - write with low byte all ones: no reply
// - every multi-byte field goes most significant first
module cracc_agent
    import cracc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire cracc_tok_t  rx_tok,
    input  wire logic        rx_valid,
    input  wire logic [15:0] rx_dest,
    output logic             rx_ready,
    output cracc_tok_t       tx_tok,
    output logic             tx_valid,
    output logic [23:0]      tx_reply,
    input  wire logic        tx_ready
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_HDR, ST_REG, ST_SIZE, ST_DATA, ST_END, ST_EXEC, ST_RSP_DATA, ST_RSP_TAIL
    } cracc_state_t;

    // map the destination code onto a register space
    function automatic cracc_space_t space_of(input logic [15:0] dest);
        if (dest == CRACC_DEST_TILE)
            return CRACC_SP_TILE;
        if (dest == CRACC_DEST_NODE)
            return CRACC_SP_NODE;
        if (dest[7:0] == CRACC_DEST_PERI)
            return CRACC_SP_PERI;
        return CRACC_SP_NONE;
    endfunction

    cracc_state_t state;     // message position
    cracc_op_t    op;        // request kind
    cracc_space_t space;     // target space
    logic [7:0]   pid;       // peripheral id
    logic [23:0]  reply;     // reply channel id
    logic [15:0]  regno;     // register number
    logic [7:0]   size;      // peripheral byte count
    logic [31:0]  word;      // write data or read data
    logic [7:0]   cnt;       // byte counter within a field
    logic         err;       // malformed or misdirected message
    logic         st_hit;
    logic [31:0]  st_rword;
    logic [7:0]   st_rbyte;

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire logic rx_fire   = rx_valid && rx_ready;
    wire logic rx_byte   = rx_fire && !rx_tok.ctrl;
    wire logic tx_free   = !tx_valid || tx_ready;
    wire logic is_peri   = (op == CRACC_OP_PRD) || (op == CRACC_OP_PWR);
    wire logic is_write  = (op == CRACC_OP_WR) || (op == CRACC_OP_PWR);
    wire logic quiet     = is_write && (reply[7:0] == CRACC_QUIET_MASK);
    wire logic [8:0] per_end = {1'b0, regno[7:0]} + {1'b0, size};
    wire logic per_ok    = (size != 8'h00) && (per_end <= CRACC_PER_BYTES) && (pid < CRACC_PER_IDS) && (regno[15:8] == 8'h00);
    wire logic fail      = err || (is_peri ? !per_ok : !st_hit);
    wire logic exec_fire = (state == ST_EXEC) && tx_free;
    wire logic [7:0] size_last = size - CRACC_ONE;
    wire logic [15:0] st_addr = is_peri ? {8'h00, regno[7:0] + cnt} : regno;
    wire logic open_ok   = space_of(rx_dest) != CRACC_SP_NONE;
    // peripheral bytes are written as they arrive, but only once the whole range is known good
    wire logic st_we = (rx_byte && (state == ST_DATA) && (op == CRACC_OP_PWR) && per_ok && !err)
                     || (exec_fire && (op == CRACC_OP_WR) && !fail);

    cracc_store u_store (
        .clock   (clock),
        .sys_rst (sys_rst),
        .space   (space),
        .pid     (pid),
        .addr    (st_addr),
        .we      (st_we),
        .wdata   (is_peri ? {24'h00_0000, rx_tok.data} : word),
        .hit     (st_hit),
        .rword   (st_rword),
        .rbyte   (st_rbyte)
    );

    ////////////////////////////////////////////////////////////////////////
    // request parser and reply sequencer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= ST_IDLE;
            op       <= CRACC_OP_WR;
            space    <= CRACC_SP_NONE;
            pid      <= 8'h00;
            reply    <= 24'h00_0000;
            regno    <= 16'h0000;
            size     <= 8'h00;
            word     <= CRACC_WORD_RST;
            cnt      <= 8'h00;
            err      <= 1'b0;
            rx_ready <= 1'b1;
            tx_valid <= 1'b0;
            tx_tok   <= '0;
            tx_reply <= 24'h00_0000;
        end else begin
            // accepted token leaves the output unless replaced below
            if (tx_valid && tx_ready)
                tx_valid <= 1'b0;
            if (rx_fire && rx_tok.ctrl && state != ST_IDLE) begin
                // any control token closes the message; only a proper end in place is clean
                err      <= err || (state != ST_END) || (rx_tok.data != CRACC_TOK_END);
                state    <= ST_EXEC;
                rx_ready <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: if (rx_fire && rx_tok.ctrl && open_ok) begin
                        space <= space_of(rx_dest);
                        pid   <= rx_dest[15:8];
                        cnt   <= 8'h00;
                        err   <= 1'b0;
                        // a one-byte peripheral register must not inherit the last message's high byte
                        regno <= 16'h0000;
                        // unknown opening tokens are dropped; there is no reply id to answer
                        if (rx_tok.data == CRACC_TOK_WRITE || rx_tok.data == CRACC_TOK_READ) begin
                            op    <= (rx_tok.data == CRACC_TOK_WRITE) ? CRACC_OP_WR : CRACC_OP_RD;
                            err   <= space_of(rx_dest) == CRACC_SP_PERI;
                            state <= ST_HDR;
                        end else if (rx_tok.data == CRACC_TOK_PREAD || rx_tok.data == CRACC_TOK_PWRITE) begin
                            op    <= (rx_tok.data == CRACC_TOK_PREAD) ? CRACC_OP_PRD : CRACC_OP_PWR;
                            err   <= space_of(rx_dest) != CRACC_SP_PERI;
                            state <= ST_HDR;
                        end
                    end
                    ST_HDR: if (rx_byte) begin
                        reply <= {reply[15:0], rx_tok.data};
                        cnt   <= (cnt == CRACC_HDR_LAST) ? 8'h00 : cnt + CRACC_ONE;
                        if (cnt == CRACC_HDR_LAST)
                            state <= ST_REG;
                    end
                    ST_REG: if (rx_byte) begin
                        regno <= {regno[7:0], rx_tok.data};
                        cnt   <= cnt + CRACC_ONE;
                        if (is_peri) begin
                            state <= ST_SIZE;
                            cnt   <= 8'h00;
                        end else if (cnt == CRACC_REG_LAST) begin
                            state <= (op == CRACC_OP_WR) ? ST_DATA : ST_END;
                            cnt   <= 8'h00;
                        end
                    end
                    ST_SIZE: if (rx_byte) begin
                        size  <= rx_tok.data;
                        state <= (op == CRACC_OP_PWR && rx_tok.data != 8'h00) ? ST_DATA : ST_END;
                    end
                    ST_DATA: if (rx_byte) begin
                        word <= {word[23:0], rx_tok.data};
                        cnt  <= cnt + CRACC_ONE;
                        if (is_peri ? (cnt == size_last) : (cnt == CRACC_WORD_LAST)) begin
                            state <= ST_END;
                            cnt   <= 8'h00;
                        end
                    end
                    ST_END: if (rx_byte)
                        err <= 1'b1;
                    ST_EXEC: if (tx_free) begin
                        cnt  <= 8'h00;
                        word <= st_rword;
                        if (quiet) begin
                            state    <= ST_IDLE;
                            rx_ready <= 1'b1;
                        end else begin
                            tx_valid <= 1'b1;
                            tx_tok   <= '{ctrl: 1'b1, data: fail ? CRACC_TOK_FAIL : CRACC_TOK_OK};
                            tx_reply <= reply;
                            state    <= (fail || is_write) ? ST_RSP_TAIL : ST_RSP_DATA;
                        end
                    end
                    ST_RSP_DATA: if (tx_free) begin
                        tx_valid <= 1'b1;
                        tx_tok   <= '{ctrl: 1'b0, data: is_peri ? st_rbyte : word[31:24]};
                        word     <= {word[23:0], 8'h00};
                        cnt      <= cnt + CRACC_ONE;
                        if (is_peri ? (cnt == size_last) : (cnt == CRACC_WORD_LAST))
                            state <= ST_RSP_TAIL;
                    end
                    ST_RSP_TAIL: if (tx_free) begin
                        tx_valid <= 1'b1;
                        tx_tok   <= '{ctrl: 1'b1, data: CRACC_TOK_END};
                        state    <= ST_IDLE;
                        rx_ready <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_open(logic [7:0] tok);
        state == ST_IDLE && rx_fire && rx_tok.ctrl && rx_tok.data == tok && open_ok;
    endsequence

    property p_open_write;
        @(posedge clock) disable iff (sys_rst) s_open(CRACC_TOK_WRITE) |=> state == ST_HDR && op == CRACC_OP_WR;
    endproperty
    a_open_write: assert property (p_open_write) else $error("write opening not taken");

    property p_open_read;
        @(posedge clock) disable iff (sys_rst) s_open(CRACC_TOK_READ) |=> state == ST_HDR && op == CRACC_OP_RD;
    endproperty
    a_open_read: assert property (p_open_read) else $error("read opening not taken");

    property p_open_pread;
        @(posedge clock) disable iff (sys_rst) s_open(CRACC_TOK_PREAD) |=> state == ST_HDR && op == CRACC_OP_PRD;
    endproperty
    a_open_pread: assert property (p_open_pread) else $error("peripheral read opening not taken");

    property p_pwrite_store;
        @(posedge clock) disable iff (sys_rst)
            st_we && is_peri |-> state == ST_DATA && op == CRACC_OP_PWR && per_ok;
    endproperty
    a_pwrite_store: assert property (p_pwrite_store) else $error("peripheral byte stored out of place");

    property p_write_ok;
        @(posedge clock) disable iff (sys_rst)
            exec_fire && is_write && !fail && !quiet |=> tx_valid && tx_tok.ctrl && tx_tok.data == CRACC_TOK_OK;
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("write success head missing");

    property p_fail_tail;
        @(posedge clock) disable iff (sys_rst)
            tx_valid && tx_ready && tx_tok.ctrl && tx_tok.data == CRACC_TOK_FAIL
            |=> tx_valid && tx_tok.ctrl && tx_tok.data == CRACC_TOK_END;
    endproperty
    a_fail_tail: assert property (p_fail_tail) else $error("failure not closed by end token");

    property p_word_msb;
        @(posedge clock) disable iff (sys_rst)
            state == ST_RSP_DATA && tx_free && op == CRACC_OP_RD && cnt == 8'h00
            |=> !tx_tok.ctrl && tx_tok.data == $past(word[31:24]);
    endproperty
    a_word_msb: assert property (p_word_msb) else $error("read word not sent high byte first");

    // closing token of a good peripheral read is loaded; cnt holds the data bytes sent
    sequence s_pread_tail;
        state == ST_RSP_TAIL && tx_free && op == CRACC_OP_PRD && !fail;
    endsequence

    property p_pread_bytes;
        @(posedge clock) disable iff (sys_rst)
            s_pread_tail |-> cnt == size;
    endproperty
    a_pread_bytes: assert property (p_pread_bytes) else $error("peripheral read byte count wrong");

    property p_quiet;
        @(posedge clock) disable iff (sys_rst) exec_fire && quiet |=> !tx_valid && state == ST_IDLE;
    endproperty
    a_quiet: assert property (p_quiet) else $error("reply sent for a quiet write");

endmodule

`default_nettype wire

// ### verif/cracc_req_model.sv
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// requesting channel end: sends whole messages and takes the replies
module cracc_req_model
    import cracc_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   slow,
    output cracc_tok_t  rx_tok,
    output logic        rx_valid,
    output logic [15:0] rx_dest,
    input  wire logic   rx_ready,
    output logic        tx_ready
);
    // quiet link at time zero
    initial begin
        rx_tok   = '0;
        rx_valid = 1'b0;
        rx_dest  = 16'h0000;
        tx_ready = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // reply side: a slow requester takes a token only every other cycle
    always @(posedge clock) begin
        #1 tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // each token is held until taken; the destination only means something
    // with the opening, so it is scrambled afterwards to catch late sampling
    task automatic send_msg(input cracc_tok_t m[$], input logic [15:0] dest);
        @(posedge clock);
        #1;
        foreach (m[i]) begin
            rx_tok   = m[i];
            rx_valid = 1'b1;
            rx_dest  = (i == 0) ? dest : ~dest;
            do @(posedge clock); while (rx_ready !== 1'b1);
            #1;
        end
        // released line shows inverted junk, never the last value
        rx_valid = 1'b0;
        rx_tok   = ~rx_tok;
        rx_dest  = ~rx_dest;
    endtask
endmodule

`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import cracc_pkg::*;
;
    logic        clock = 1'b0;    // 125 MHz system clock
    logic        sys_rst = 1'b1;  // asynchronous reset
    logic        slow = 1'b0;     // requester stalls replies
    cracc_tok_t  rx_tok;
    cracc_tok_t  tx_tok;
    logic        rx_valid;
    logic        rx_ready;
    logic        tx_valid;
    logic        tx_ready;
    logic [15:0] rx_dest;
    logic [23:0] tx_reply;
    logic [23:0] rid;             // reply channel id of a message
    logic [31:0] r;
    logic [31:0] q;
    int          bad_count = 0;
    int          checks_done = 0;
    int          seed = 24;
    logic [32:0] exp_q[$];        // expected {reply id, token}
    cracc_tok_t  m[$];            // message under construction
    logic [31:0] cfg_ref[2][16];  // tile and node words
    logic [7:0]  per_ref[4][64];  // peripheral bytes

    cracc_agent i_dut (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .rx_tok   (rx_tok),
        .rx_valid (rx_valid),
        .rx_dest  (rx_dest),
        .rx_ready (rx_ready),
        .tx_tok   (tx_tok),
        .tx_valid (tx_valid),
        .tx_reply (tx_reply),
        .tx_ready (tx_ready)
    );

    cracc_req_model i_req (
        .clock    (clock),
        .slow     (slow),
        .rx_tok   (rx_tok),
        .rx_valid (rx_valid),
        .rx_dest  (rx_dest),
        .rx_ready (rx_ready),
        .tx_ready (tx_ready)
    );

    // free-running clock
    initial begin
        forever #4 clock = ~clock;
    end

    //////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    // append n tokens, most significant byte first
    task automatic put(input logic c, input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) m.push_back('{c, v[8*i +: 8]});
    endtask

    task automatic want(input logic [23:0] rr, input logic [7:0] t, input logic c);
        exp_q.push_back({rr, c, t});
    endtask

    // tile or node access; success follows from the register number, read data from the reference copy
    task automatic cfg_op(input logic rd, input logic nd, input logic [15:0] rg, input logic [31:0] d,
                          input logic [23:0] rr);
        logic ok;
        ok = (rg < CRACC_CFG_WORDS);
        m.delete();
        put(1'b1, 32'(rd ? CRACC_TOK_READ : CRACC_TOK_WRITE), 1);
        put(1'b0, 32'(rr), 3);
        put(1'b0, 32'(rg), 2);
        if (!rd) put(1'b0, d, 4);
        put(1'b1, 32'(CRACC_TOK_END), 1);
        if (rd || rr[7:0] !== CRACC_QUIET_MASK) begin
            want(rr, ok ? CRACC_TOK_OK : CRACC_TOK_FAIL, 1'b1);
            if (ok && rd) for (int i = 3; i >= 0; i--) want(rr, cfg_ref[nd][rg[3:0]][8*i +: 8], 1'b0);
            want(rr, CRACC_TOK_END, 1'b1);
        end
        if (ok && !rd) cfg_ref[nd][rg[3:0]] = d;
        i_req.send_msg(m, nd ? CRACC_DEST_NODE : CRACC_DEST_TILE);
    endtask

    // peripheral access of sz bytes from rg upward
    task automatic per_op(input logic rd, input logic [7:0] pid, input logic [7:0] rg, input logic [7:0] sz,
                          input logic [23:0] rr);
        logic       ok;
        logic [7:0] b;
        ok = pid < CRACC_PER_IDS && sz != 8'h00 && ({1'b0, rg} + {1'b0, sz}) <= CRACC_PER_BYTES;
        m.delete();
        put(1'b1, 32'(rd ? CRACC_TOK_PREAD : CRACC_TOK_PWRITE), 1);
        put(1'b0, 32'(rr), 3);
        put(1'b0, {16'h0000, rg, sz}, 2);
        for (int i = 0; i < sz && !rd; i++) begin
            b = $random(seed);
            put(1'b0, 32'(b), 1);
            if (ok) per_ref[pid[1:0]][rg + i] = b;
        end
        put(1'b1, 32'(CRACC_TOK_END), 1);
        if (rd || rr[7:0] !== CRACC_QUIET_MASK) begin
            want(rr, ok ? CRACC_TOK_OK : CRACC_TOK_FAIL, 1'b1);
            for (int i = 0; i < sz && ok && rd; i++) want(rr, per_ref[pid[1:0]][rg + i], 1'b0);
            want(rr, CRACC_TOK_END, 1'b1);
        end
        i_req.send_msg(m, {pid, CRACC_DEST_PERI});
    endtask

    // malformed message that must be answered with failure
    task automatic bad_msg(input logic [7:0] op, input logic [15:0] dest, input int extra, input logic [7:0] cl);
        m.delete();
        put(1'b1, 32'(op), 1);
        put(1'b0, 32'h00AB_CD12, 3);
        put(1'b0, $random(seed), 2);
        repeat (extra) put(1'b0, $random(seed), 1);
        put(1'b1, 32'(cl), 1);
        want(24'hAB_CD12, CRACC_TOK_FAIL, 1'b1);
        want(24'hAB_CD12, CRACC_TOK_END, 1'b1);
        i_req.send_msg(m, dest);
    endtask

    // wait, bounded, until every expected reply has come
    task automatic drain(input string name);
        for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge clock);
        repeat (8) @(posedge clock);
        chk(33'(exp_q.size()), 33'h0_0000_0000);
        $display("test %s done", name);
    endtask

    task automatic do_reset;
        // raise reset off the clock edge
        #1 sys_rst = 1'b1;
        repeat (6) @(posedge clock);
        chk({32'h0000_0000, rx_ready}, 33'h0_0000_0001);
        chk({32'h0000_0000, tx_valid}, 33'h0_0000_0000);
        #1 sys_rst = 1'b0;
        cfg_ref = '{default: '0};
        per_ref = '{default: '0};
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    // reply monitor: every taken token is matched against the oldest note
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) chk(33'h0_0000_0000, {tx_reply, tx_tok});
            else chk(exp_q.pop_front(), {tx_reply, tx_tok});
        end
    end

    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        end_sim();
    end

    //////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        cfg_op(1'b0, 1'b0, 16'h000F, 32'h1234_5678, 24'h00_1102);
        cfg_op(1'b0, 1'b1, 16'h000F, 32'h9ABC_DEF0, 24'h00_1103);
        cfg_op(1'b1, 1'b0, 16'h000F, 32'h0000_0000, 24'h00_1104);
        cfg_op(1'b1, 1'b1, 16'h000F, 32'h0000_0000, 24'h00_1105);
        cfg_op(1'b0, 1'b0, 16'h0010, 32'hFFFF_FFFF, 24'h00_1106);
        cfg_op(1'b1, 1'b1, 16'h0010, 32'h0000_0000, 24'h00_1107);
        cfg_op(1'b0, 1'b1, 16'h0000, 32'hA5A5_5A5A, 24'h12_34FF);
        cfg_op(1'b1, 1'b1, 16'h0000, 32'h0000_0000, 24'h12_34FF);
        drain("config");
        per_op(1'b0, 8'h01, 8'h3C, 8'h04, 24'h00_2201);
        per_op(1'b1, 8'h01, 8'h3C, 8'h04, 24'h00_2202);
        per_op(1'b1, 8'h01, 8'h3D, 8'h04, 24'h00_2203);
        per_op(1'b1, 8'h04, 8'h00, 8'h01, 24'h00_2204);
        per_op(1'b1, 8'h00, 8'h00, 8'h00, 24'h00_2205);
        drain("peripheral");
        bad_msg(CRACC_TOK_WRITE, CRACC_DEST_TILE, 5, CRACC_TOK_END);
        bad_msg(CRACC_TOK_READ, CRACC_DEST_NODE, 0, 8'h02);
        bad_msg(CRACC_TOK_READ, {8'h01, CRACC_DEST_PERI}, 0, CRACC_TOK_END);
        bad_msg(CRACC_TOK_PREAD, CRACC_DEST_NODE, 0, CRACC_TOK_END);
        m.delete();
        put(1'b1, 32'(CRACC_TOK_READ), 1);
        put(1'b0, $random(seed), 4);
        put(1'b1, 32'(CRACC_TOK_END), 1);
        i_req.send_msg(m, 16'h1234);
        drain("malformed");
        for (int k = 0; k < 60; k++) begin
            r = $random(seed);
            q = $random(seed);
            slow = r[29];
            rid = r[23:0];
            if (r[31:30] == 2'b00) rid[7:0] = CRACC_QUIET_MASK;
            if (r[28]) per_op(r[26], {5'h00, q[10:8]}, {2'h0, q[21:16]}, {5'h00, q[26:24]}, rid);
            else cfg_op(r[26], r[27], {11'h000, q[4:0]}, $random(seed), rid);
        end
        drain("random");
        slow = 1'b0;
        do_reset();
        cfg_op(1'b1, 1'b0, 16'h000F, 32'h0000_0000, 24'h00_3301);
        per_op(1'b1, 8'h01, 8'h3C, 8'h04, 24'h00_3302);
        drain("reset");
        end_sim();
    end
endmodule

`default_nettype wire
